// [design/pmic_regs_pkg.sv]
// Purpose: shared constants and carriers for the power-management register bank
// Assumes: 8-bit subaddress and data from the serial-bus engine
// Notes:   key xor value is arbitrary and neutral
package pmic_regs_pkg;

    // ==========================================================
    // subaddresses
    localparam logic [7:0] ADDR_CONTROL   = 8'h06;
    localparam logic [7:0] ADDR_FLAGS     = 8'h07;
    localparam logic [7:0] ADDR_KEY       = 8'h10;
    localparam logic [7:0] ADDR_CONV_EN   = 8'h11;

    // ==========================================================
    // reset values and field layout
    localparam logic [7:0] CONTROL_RESET  = 8'h00;
    localparam logic [7:0] FLAGS_RESET    = 8'h00;
    localparam logic [7:0] CONV_EN_RESET  = 8'h00;
    localparam logic [7:0] KEY_READ_VALUE = 8'h00;
    localparam logic [7:0] CONTROL_MASK   = 8'h03;
    localparam logic [7:0] CONV_EN_MASK   = 8'h3F;
    localparam int         CTRL_CC_ACQ    = 0;
    localparam int         CTRL_PF_SHDN   = 1;
    localparam int         EN_BUCK5       = 4;
    localparam int         EN_BUCK6       = 5;
    localparam logic [5:0] SEQ_RAIL_MASK  = 6'h1F;
    // arbitrary value: unlock key is subaddress xor this
    localparam logic [7:0] KEY_XOR        = 8'h5A;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [5:0] set;
        logic [5:0] clr;
    } seq_upd_t;

    typedef struct packed {
        logic       from_suspend;
        logic       from_off;
        logic [7:0] rails_on;
    } wake_evt_t;

endpackage

// [design/pmic_control_flag_enable_regs.sv]
// Purpose: control, suspend flag, key and converter enable registers
// Assumes: register requests come from the serial-bus engine on mclk
// Notes:   seal status and power-fail pins are asynchronous and synchronised here
//
// Operation
// - power-fail shutdown enabled and power-fail low: all rails off, OFF state.
// - shutdown disabled: power-fail output changes nothing.
// - writing 1 to acquisition start pulses one measurement; bit self-clears.
// - suspend flag register read-only at 0x07, resets to zero.
// - flag reads 1 after wake from suspend with that rail on.
// - flag reads 0 after wake from off or with rail off.
// - key register at 0x10 accepts writes used for unlocking.
// - reading key register always returns 0x00.
// - converter enable at 0x11, resets 0x00, writes need unlock.
// - enable bits 5..0 switch buck6..buck1 on when 1.
// - sequencer updates enables of rails 1 to 5 itself.
// - buck6 may be disabled only while seal status is 0; a power-fail trip still clears it while the seal is broken.
// - buck5 may be disabled only while seal status is 0; the sequencer and a power-fail trip still clear it while the seal is broken.
// - seal status 0 when fresh, 1 once broken.
`timescale 1ns/1ns
module pmic_control_flag_enable_regs
    import pmic_regs_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      rst_n,
    input  wire logic      ce,
    input  wire reg_req_t  req,
    input  wire seq_upd_t  seq_upd,
    input  wire wake_evt_t wake_evt,
    input  wire logic      power_fail_out_n,
    input  wire logic      seal_broken_pin,
    output logic [7:0]     rd_data_q,
    output logic           rd_valid_q,
    output logic [5:0]     rail_en_q,
    output logic           shutdown_req_q,
    output logic           coin_cell_acq_start_q,
    output logic           freshness_seal_status_q
);

    // ==========================================================
    // pin synchronisers
    logic [1:0] pfo_sync_q;
    logic [1:0] seal_sync_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pfo_sync_q  <= 2'h3;
            seal_sync_q <= 2'h0;
        end else if (ce) begin
            pfo_sync_q  <= {pfo_sync_q[0], power_fail_out_n};
            seal_sync_q <= {seal_sync_q[0], seal_broken_pin};
        end
    end

    logic pfo_low;
    assign pfo_low = !pfo_sync_q[1];

    // seal status as seen by software
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            freshness_seal_status_q <= 1'b0;
        end else if (ce) begin
            freshness_seal_status_q <= seal_sync_q[1];
        end
    end

    // ==========================================================
    // write decode and unlock
    logic wr_ctrl;
    logic wr_key;
    logic wr_en_reg;
    logic unlock_q;
    logic key_match;

    assign wr_ctrl   = req.wr && (req.addr == ADDR_CONTROL);
    assign wr_key    = req.wr && (req.addr == ADDR_KEY);
    // one write after a matching key, any other write consumes it
    assign wr_en_reg = req.wr && (req.addr == ADDR_CONV_EN) && unlock_q;

    // arms only on the exact key; a wrong key disarms as well
    assign key_match = wr_key && (req.wdata == (ADDR_CONV_EN ^ KEY_XOR));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            unlock_q <= 1'b0;
        end else if (ce && req.wr) begin
            unlock_q <= key_match;
        end
    end

    // ==========================================================
    // control register
    logic pf_shdn_en_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pf_shdn_en_q <= CONTROL_RESET[CTRL_PF_SHDN];
        end else if (ce && wr_ctrl) begin
            pf_shdn_en_q <= req.wdata[CTRL_PF_SHDN];
        end
    end

    // start pulse lasts one cycle; the read view ties the bit to 0
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            coin_cell_acq_start_q <= 1'b0;
        end else if (ce) begin
            coin_cell_acq_start_q <= wr_ctrl && req.wdata[CTRL_CC_ACQ];
        end
    end

    // latched until reset; the OFF state ends this block's life
    logic pf_trip;
    assign pf_trip = pf_shdn_en_q && pfo_low;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shutdown_req_q <= 1'b0;
        end else if (ce && pf_trip) begin
            shutdown_req_q <= 1'b1;
        end
    end

    // ==========================================================
    // converter enables
    logic [5:0] host_en;
    logic [5:0] en_d;
    logic [5:0] seq_set;
    logic [5:0] seq_clr;
    logic [5:0] seal_hold;

    // only rails 1 to 5 follow the sequencer; buck6 stays under host control
    assign seq_set = seq_upd.set & SEQ_RAIL_MASK;
    assign seq_clr = seq_upd.clr & SEQ_RAIL_MASK;

    // backup rails cannot be cleared by the host once the seal is broken
    always_comb begin
        seal_hold = 6'h00;
        if (freshness_seal_status_q) begin
            seal_hold[EN_BUCK6] = rail_en_q[EN_BUCK6];
            seal_hold[EN_BUCK5] = rail_en_q[EN_BUCK5];
        end
    end

    always_comb begin
        host_en = (req.wdata[5:0] & CONV_EN_MASK[5:0]) | seal_hold;
        en_d    = wr_en_reg ? host_en : rail_en_q;
        // sequencer wins over a host write in the same cycle; set wins over clear
        en_d    = (en_d & ~seq_clr) | seq_set;
        // power-fail trip overrides sequencer and host alike
        if (pf_trip) begin
            en_d = 6'h00;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rail_en_q <= CONV_EN_RESET[5:0];
        end else if (ce) begin
            rail_en_q <= en_d;
        end
    end

    // ==========================================================
    // suspend wake flags
    logic [7:0] flags_q;
    logic       wake_clear;
    logic       wake_load;

    // a wake from OFF outranks a wake from SUSPEND in the same cycle
    assign wake_clear = wake_evt.from_off;
    assign wake_load  = wake_evt.from_suspend && !wake_evt.from_off;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= FLAGS_RESET;
        end else if (ce) begin
            if (wake_clear) begin
                flags_q <= 8'h00;
            end else if (wake_load) begin
                flags_q <= wake_evt.rails_on;
            end
        end
    end

    // ==========================================================
    // read path, one cycle latency
    logic [7:0] rd_mux;
    logic [7:0] ctrl_view;
    logic [7:0] conv_view;

    // reserved bits forced low so a wider store can never leak into a read
    assign ctrl_view = {6'h00, pf_shdn_en_q, 1'b0} & CONTROL_MASK;
    assign conv_view = {2'h0, rail_en_q} & CONV_EN_MASK;

    always_comb begin
        case (req.addr)
            ADDR_CONTROL: rd_mux = ctrl_view;
            ADDR_FLAGS:   rd_mux = flags_q;
            ADDR_KEY:     rd_mux = KEY_READ_VALUE;
            ADDR_CONV_EN: rd_mux = conv_view;
            default:      rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else if (ce) begin
            rd_valid_q <= req.rd;
            if (req.rd) begin
                rd_data_q <= rd_mux;
            end
        end
    end

endmodule

// [verif/host_model.sv]
// Purpose: host side issuing register bytes
// Assumes: requests move at the falling edge
// Notes: one idle cycle between requests
`timescale 1ns/1ns
module host_model import pmic_regs_pkg::*; (
    input wire logic [7:0] rd_data_q,
    input wire logic       mclk,
    output reg_req_t       req
);
    logic [7:0] rdat;
    initial req = '0;
    // request held over one rising edge, read data taken one cycle later
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk) req <= {w, !w, a, d};
        @(negedge mclk) rdat = rd_data_q;
        req <= '0;
    endtask
endmodule

// [verif/regs_monitor.sv]
// Purpose: port checker
// Assumes: single clock domain
// Notes: bound by name below
`timescale 1ns/1ns
module regs_monitor import pmic_regs_pkg::*; (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       ce,
    input wire reg_req_t   req,
    input wire logic       power_fail_out_n,
    input wire logic [7:0] rd_data_q,
    input wire logic [5:0] rail_en_q,
    input wire logic       shutdown_req_q,
    input wire logic       coin_cell_acq_start_q,
    input wire logic       freshness_seal_status_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire rk = ce & req.rd;
    wire wc = ce & req.wr & (req.addr == ADDR_CONTROL);
    property p_key; rk && req.addr == ADDR_KEY |=> rd_data_q == 8'h00; endproperty
    a_key: assert property (p_key) else $error("key read");
    property p_ctl; rk && req.addr == ADDR_CONTROL |=> (rd_data_q & 8'hFD) == 8'h00; endproperty
    a_ctl: assert property (p_ctl) else $error("ctl read");
    property p_en; rk && req.addr == ADDR_CONV_EN |=> rd_data_q == {2'h0, $past(rail_en_q)}; endproperty
    a_en: assert property (p_en) else $error("en read");
    property p_acq; wc && req.wdata[0] |=> coin_cell_acq_start_q ##1
        (!coin_cell_acq_start_q || $past(wc && req.wdata[0]) || !$past(ce)); endproperty
    a_acq: assert property (p_acq) else $error("acq pulse");
    property p_no; wc && !req.wdata[0] |=> !coin_cell_acq_start_q; endproperty
    a_no: assert property (p_no) else $error("acq zero");
    property p_off; shutdown_req_q |-> rail_en_q == 6'h00 ##1 shutdown_req_q; endproperty
    a_off: assert property (p_off) else $error("off");
    property p_why; $rose(shutdown_req_q) |-> !$past(power_fail_out_n, 3); endproperty
    a_why: assert property (p_why) else $error("cause");
    property p_s6; $fell(rail_en_q[5]) && !shutdown_req_q |-> !$past(freshness_seal_status_q); endproperty
    a_s6: assert property (p_s6) else $error("seal");
endmodule
bind pmic_control_flag_enable_regs regs_monitor mon (.*);

// [verif/testbench.sv]
// Purpose: self-checking bench
// Assumes: 50 MHz, inputs move at falling edge
// Notes: pins need three cycles through sync
`timescale 1ns/1ns
module testbench import pmic_regs_pkg::*; ;
    logic mclk = 1'h0, rst_n = 1'h0, ce = 1'h1, power_fail_out_n = 1'h1, seal_broken_pin = 1'h0;
    logic rd_valid_q, shutdown_req_q, coin_cell_acq_start_q, freshness_seal_status_q;
    logic [7:0] rd_data_q, key = ADDR_CONV_EN ^ KEY_XOR;
    logic [5:0] rail_en_q;
    seq_upd_t seq_upd = '0;
    wake_evt_t wake_evt = '0;
    reg_req_t req;
    int mismatches = 0, n_compared = 0, cyc = 0;
    host_model host (.*);
    pmic_control_flag_enable_regs dut (.*);
    initial forever #10 mclk = ~mclk;
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin mismatches++; $display("[ERR] %s exp %h got %h", n, e, g); end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d); host.xfer(1'h1, a, d); endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        host.xfer(1'h0, a, 8'h00);
        chk("rd", e, host.rdat);
        chk("valid", 8'h01, {7'h0, rd_valid_q});
    endtask
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard, run needs under a hundred cycles
    always @(posedge mclk) if (++cyc == 1000) begin
        mismatches++; stop_test();
    end
    task t_regs;
        rd(ADDR_FLAGS, 8'h00); rd(ADDR_CONV_EN, 8'h00);
        wr(ADDR_CONV_EN, 8'hFF); rd(ADDR_CONV_EN, 8'h00);
        wr(ADDR_KEY, key); wr(ADDR_CONV_EN, 8'hFF); rd(ADDR_CONV_EN, 8'h3F);
        wr(ADDR_CONV_EN, 8'h00); rd(ADDR_CONV_EN, 8'h3F);
        wr(ADDR_FLAGS, 8'hFF); rd(ADDR_FLAGS, 8'h00); rd(ADDR_KEY, 8'h00);
        wake_evt = {1'h1, 1'h0, 8'hA5}; @(negedge mclk) wake_evt = '0; rd(ADDR_FLAGS, 8'hA5);
        wake_evt = {1'h0, 1'h1, 8'hFF}; @(negedge mclk) wake_evt = '0; rd(ADDR_FLAGS, 8'h00);
        $display("regs end");
    endtask
    task t_seal;
        seal_broken_pin = 1'h1; repeat (4) @(negedge mclk);
        chk("seal", 8'h01, {7'h0, freshness_seal_status_q});
        wr(ADDR_KEY, key); wr(ADDR_CONV_EN, 8'h00); rd(ADDR_CONV_EN, 8'h30);
        seq_upd = {6'h3F, 6'h02}; @(negedge mclk) seq_upd = '0; rd(ADDR_CONV_EN, 8'h3F);
        seq_upd = {6'h00, 6'h3F}; @(negedge mclk) seq_upd = '0; rd(ADDR_CONV_EN, 8'h20);
        seal_broken_pin = 1'h0; repeat (4) @(negedge mclk);
        wr(ADDR_KEY, key); wr(ADDR_CONV_EN, 8'h00); rd(ADDR_CONV_EN, 8'h00);
        $display("seal end");
    endtask
    task t_pf;
        wr(ADDR_CONTROL, 8'h01); chk("acq", 8'h01, {7'h0, coin_cell_acq_start_q});
        rd(ADDR_CONTROL, 8'h00);
        ce = 1'h0; wr(ADDR_CONTROL, 8'h02); ce = 1'h1; rd(ADDR_CONTROL, 8'h00);
        seq_upd = {6'h1F, 6'h00}; @(negedge mclk) seq_upd = '0;
        power_fail_out_n = 1'h0; repeat (5) @(negedge mclk);
        chk("shut", 8'h1F, {1'h0, shutdown_req_q, rail_en_q});
        power_fail_out_n = 1'h1; repeat (3) @(negedge mclk);
        wr(ADDR_CONTROL, 8'hFE); rd(ADDR_CONTROL, 8'h02);
        power_fail_out_n = 1'h0; repeat (4) @(negedge mclk);
        chk("shut", 8'h40, {1'h0, shutdown_req_q, rail_en_q});
        $display("fail end");
    endtask
    initial begin
        repeat (4) @(negedge mclk);
        rst_n = 1'h1;
        t_regs(); t_seal(); t_pf(); stop_test();
    end
endmodule
